// file: fphz_interlock.sv
// Issue interlock: data hazards, scoreboards and pipeline resources
// Operation
// - Vector op after load multiple waits only for its loaded registers, forwarded.
// - Arithmetic consumer waits in issue until producer writeback, result forwarded.
// - Compliance mode: load multiple held until source locks on its registers clear.
// - Fast mode: multiply family locks sources only beyond four single or two double.
// - Fast mode: scalar instructions place no source locks.
// - Transfer after unfinished transfer stalls; host stall lengthens the transfer.
// - Double multiply holds multiply-add pipe two cycles, next arithmetic stalls one.
// - Divide blocks divide pipe 15 cycles single, 29 double.
// - Vector divide uses shared first execute per iteration; arithmetic waits for last.
// - Load/store pipe never resource-stalls arithmetic and vice versa.
// - Single load after load multiple held until its final execute cycle.
// - Independent vector op issues the cycle after load multiple issues.
// - Single divide iteration runs 15 cycles; first cycle shared with multiply-add.
// - Length code 1 means two iterations, 3 four; stride code 0 means one.
// - Stride-one four-iteration vector from register 7 wraps to 0, 1, 2.
// - Compliance mode clears each iteration's source locks in its first execute.
`timescale 1ns/1ps
module fphz_interlock (
  input wire logic ref_clk,             // Core clock
  input wire logic rstn,                // Async reset, active low
  input wire logic fast_mode,           // Reduced locking mode
  input wire logic [2:0] vector_length_field, // Iterations minus one
  input wire logic [1:0] stride_field,  // Stride code
  input wire logic req_valid,           // Instruction waiting in issue
  input wire logic [2:0] req_op,        // fphz_op_t code
  input wire logic req_dp,              // Double precision
  input wire logic req_vec,             // Short vector operation
  input wire logic [4:0] req_dst,       // First destination register
  input wire logic [4:0] req_src_a,     // First source A
  input wire logic [4:0] req_src_b,     // First source B
  input wire logic [4:0] req_count,     // Registers in a load multiple
  input wire logic host_ls_stall,       // Host holds current transfer
  input wire logic arith_wb,            // Arithmetic writeback pulse
  input wire logic [4:0] arith_wb_reg,  // Register written back
  output logic issue,                   // Instruction issued this cycle
  output logic fwd_load,                // Operand taken from load forwarding
  output logic fwd_arith,               // Operand taken from arithmetic writeback
  output logic ls_busy                  // Load/store pipe occupied
);
  ////////////////////////////////////////////////////////////////////////
  // Decode
  fphz_pkg::fphz_op_t op;
  logic is_arith, is_ls, is_mul;
  logic [31:0] src_all, src_fast, dst_all, src_lock;
  logic [2:0] fast_first;
  always_comb begin
    op = fphz_pkg::fphz_op_t'(req_op);
    is_ls = op == fphz_pkg::FPHZ_OP_LOAD_SINGLE || op == fphz_pkg::FPHZ_OP_LOAD_MULTIPLE;
    is_arith = op == fphz_pkg::FPHZ_OP_ADD || op == fphz_pkg::FPHZ_OP_MUL || op == fphz_pkg::FPHZ_OP_DIV;
    is_mul = op == fphz_pkg::FPHZ_OP_MUL;
    // Fast mode locks only iterations beyond the short limit
    fast_first = req_dp ? 3'(fphz_pkg::FAST_DP_MAX_ITER) : 3'(fphz_pkg::FAST_SP_MAX_ITER);
  end
  logic [2:0] vlen;
  always_comb vlen = req_vec ? vector_length_field : 3'h0;
  logic [31:0] src_a_m, src_b_m, src_af_m, src_bf_m;
  fphz_reg_vec u_sa (.base(req_src_a), .len(vlen), .stride(stride_field), .first_iter(3'h0), .mask(src_a_m));
  fphz_reg_vec u_sb (.base(req_src_b), .len(vlen), .stride(stride_field), .first_iter(3'h0), .mask(src_b_m));
  fphz_reg_vec u_fa (.base(req_src_a), .len(vlen), .stride(stride_field), .first_iter(fast_first), .mask(src_af_m));
  fphz_reg_vec u_fb (.base(req_src_b), .len(vlen), .stride(stride_field), .first_iter(fast_first), .mask(src_bf_m));
  fphz_reg_vec u_d (.base(req_dst), .len(vlen), .stride(stride_field), .first_iter(3'h0), .mask(dst_all));
  // Register used by one iteration, wrapping inside its bank
  function automatic logic [4:0] iter_reg(input logic [4:0] base, input logic [1:0] stride, input logic [2:0] it);
    logic [2:0] step;
    step = (stride == fphz_pkg::STRIDE_ONE) ? 3'h1 : 3'h2;
    iter_reg = {base[4:3], 3'(base[2:0] + 3'(step * it))};
  endfunction
  logic [31:0] ld_dst;
  logic [4:0] ld_cnt;
  logic [31:0] it_mask [8];                 // Locked sources of each iteration
  always_comb begin
    src_all = src_a_m | src_b_m;
    src_fast = src_af_m | src_bf_m;
    ld_cnt = (op == fphz_pkg::FPHZ_OP_LOAD_MULTIPLE) ? req_count : 5'h01;
    ld_dst = '0;
    for (int k = 0; k < fphz_pkg::NREGS; k++) begin
      if (5'(k - int'(req_dst)) < ld_cnt) ld_dst[k] = 1'b1;
    end
    if (!fast_mode) src_lock = (is_arith && op != fphz_pkg::FPHZ_OP_DIV) ? src_all : '0;
    else if (is_mul && req_vec) src_lock = src_fast;
    else src_lock = '0;
    for (int m = 0; m < 8; m++) begin
      it_mask[m] = '0;
      if (3'(m) <= vlen && (!fast_mode || 3'(m) >= fast_first)) begin
        it_mask[m][iter_reg(req_src_a, stride_field, 3'(m))] = 1'b1;
        it_mask[m][iter_reg(req_src_b, stride_field, 3'(m))] = 1'b1;
      end
      it_mask[m] = it_mask[m] & src_lock;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Scoreboards and pipeline state
  logic [31:0] ld_pend_reg, ld_pend_next;   // Registers still arriving from loads
  logic [31:0] ar_pend_reg, ar_pend_next;   // Registers awaiting arithmetic writeback
  logic [31:0] src_sb_reg, src_sb_next;     // Source-register locks
  logic [31:0] it_src_reg [8];              // Per-iteration source locks
  logic [31:0] it_src_next [8];
  logic [3:0] it_left_reg, it_left_next;    // Iterations left in first execute
  logic [2:0] it_idx_reg, it_idx_next;
  logic mac_busy_reg, mac_busy_next;        // Double multiply second cycle
  logic [4:0] div_cnt_reg, div_cnt_next;    // Divide pipe block counter
  logic [3:0] dv_it_cnt_reg, dv_it_cnt_next;// Cycles left in a divide iteration
  logic [2:0] dv_left_reg, dv_left_next;    // Vector divide iterations not yet in shared cycle
  fphz_pkg::fphz_ls_state_t ls_st_reg, ls_st_next;
  logic [4:0] ls_left_reg, ls_left_next;    // Transfers left in a load multiple
  logic [4:0] ls_idx_reg, ls_idx_next;      // Register taking the next transfer
  logic [31:0] ld_arrive, ld_wait, ar_wait;
  logic data_ok, res_ok;
  always_comb begin
    // Registers arriving this cycle are forwarded, not waited for
    ld_arrive = '0;
    if (ls_st_reg == fphz_pkg::FPHZ_LS_BUSY && !host_ls_stall) ld_arrive[ls_idx_reg] = 1'b1;
    ld_wait = ld_pend_reg & ~ld_arrive;
    ar_wait = ar_pend_reg;
    if (arith_wb) ar_wait[arith_wb_reg] = 1'b0;
    // Data hazards
    data_ok = 1'b1;
    if (is_arith && |(src_all & (ld_wait | ar_wait))) data_ok = 1'b0;
    if (op == fphz_pkg::FPHZ_OP_LOAD_MULTIPLE && |(ld_dst & src_sb_reg)) data_ok = 1'b0;
    if (is_arith && |(dst_all & src_sb_reg)) data_ok = 1'b0;
    // Resources: load/store checks only load/store state
    res_ok = 1'b1;
    if (is_ls) res_ok = ls_st_reg == fphz_pkg::FPHZ_LS_IDLE || (ls_left_reg <= 5'h1 && !host_ls_stall);
    if (is_arith) res_ok = !mac_busy_reg && it_left_reg <= 4'h1 && dv_left_reg == 3'h0;
    if (op == fphz_pkg::FPHZ_OP_DIV && div_cnt_reg != 5'h0) res_ok = 1'b0;
    issue = req_valid && op != fphz_pkg::FPHZ_OP_NONE && data_ok && res_ok;
    fwd_load = issue && is_arith && |(src_all & ld_arrive);
  end
  always_comb begin
    ld_pend_next = ld_pend_reg & ~ld_arrive;
    ar_pend_next = ar_pend_reg;
    if (arith_wb) ar_pend_next[arith_wb_reg] = 1'b0;
    src_sb_next = src_sb_reg;
    it_src_next = it_src_reg;
    it_left_next = it_left_reg;
    it_idx_next = it_idx_reg;
    mac_busy_next = 1'b0;
    div_cnt_next = (div_cnt_reg != 5'h0) ? div_cnt_reg - 5'h1 : 5'h0;
    dv_it_cnt_next = dv_it_cnt_reg;
    dv_left_next = dv_left_reg;
    ls_st_next = ls_st_reg;
    ls_left_next = ls_left_reg;
    ls_idx_next = ls_idx_reg;
    // Transfer progress, frozen by host stall
    if (ls_st_reg == fphz_pkg::FPHZ_LS_BUSY && !host_ls_stall) begin
      ls_idx_next = ls_idx_reg + 5'h1;
      ls_left_next = ls_left_reg - 5'h1;
      if (ls_left_reg == 5'h1) ls_st_next = fphz_pkg::FPHZ_LS_IDLE;
    end
    // Vector iterations step through first execute; locks clear per iteration
    if (it_left_reg != 4'h0) begin
      src_sb_next = src_sb_next & ~it_src_reg[it_idx_reg];
      it_left_next = it_left_reg - 4'h1;
      it_idx_next = it_idx_reg + 3'h1;
    end
    // Vector divide iterations
    if (dv_left_reg != 3'h0) begin
      if (dv_it_cnt_reg == 4'h0) begin
        dv_left_next = dv_left_reg - 3'h1;
        dv_it_cnt_next = 4'(fphz_pkg::SP_DIV_ITER);
      end else begin
        dv_it_cnt_next = dv_it_cnt_reg - 4'h1;
      end
    end
    if (issue) begin
      if (is_ls) begin
        ls_st_next = fphz_pkg::FPHZ_LS_BUSY;
        ls_left_next = (op == fphz_pkg::FPHZ_OP_LOAD_MULTIPLE) ? req_count : 5'h1;
        ls_idx_next = req_dst;
        ld_pend_next = ld_pend_next | ld_dst;
      end
      if (is_arith) begin
        ar_pend_next = ar_pend_next | dst_all;
        src_sb_next = src_sb_next | src_lock;
        if (is_mul && req_dp) mac_busy_next = 1'b1;
      end
      // Every add or multiply iteration, scalar too, passes first execute once
      if (is_arith && op != fphz_pkg::FPHZ_OP_DIV) begin
        it_left_next = 4'(vlen) + 4'h1;
        it_idx_next = 3'h0;
        it_src_next = it_mask;
      end
      if (op == fphz_pkg::FPHZ_OP_DIV) begin
        div_cnt_next = req_dp ? 5'(fphz_pkg::DP_DIV_BLOCK - 1) : 5'(fphz_pkg::SP_DIV_BLOCK - 1);
        dv_left_next = vlen;
        dv_it_cnt_next = 4'(fphz_pkg::SP_DIV_ITER);
      end
    end
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ld_pend_reg <= '0;
      ar_pend_reg <= '0;
      src_sb_reg <= '0;
      for (int j = 0; j < 8; j++) it_src_reg[j] <= '0;
      it_left_reg <= '0;
      it_idx_reg <= '0;
      mac_busy_reg <= 1'b0;
      div_cnt_reg <= '0;
      dv_it_cnt_reg <= '0;
      dv_left_reg <= '0;
      ls_st_reg <= fphz_pkg::FPHZ_LS_IDLE;
      ls_left_reg <= '0;
      ls_idx_reg <= '0;
    end else begin
      ld_pend_reg <= ld_pend_next;
      ar_pend_reg <= ar_pend_next;
      src_sb_reg <= src_sb_next;
      for (int j = 0; j < 8; j++) it_src_reg[j] <= it_src_next[j];
      it_left_reg <= it_left_next;
      it_idx_reg <= it_idx_next;
      mac_busy_reg <= mac_busy_next;
      div_cnt_reg <= div_cnt_next;
      dv_it_cnt_reg <= dv_it_cnt_next;
      dv_left_reg <= dv_left_next;
      ls_st_reg <= ls_st_next;
      ls_left_reg <= ls_left_next;
      ls_idx_reg <= ls_idx_next;
    end
  end
  always_comb begin
    ls_busy = ls_st_reg == fphz_pkg::FPHZ_LS_BUSY;
    fwd_arith = issue && is_arith && arith_wb && src_all[arith_wb_reg];
  end
  ////////////////////////////////////////////////////////////////////////
  // Checks
  a_div_block_sp: assert property (@(posedge ref_clk) disable iff (!rstn)
    issue && op == fphz_pkg::FPHZ_OP_DIV ##1 req_valid && op == fphz_pkg::FPHZ_OP_DIV |-> !issue)
    else $error("divide issued during divide block");
  a_dp_mul_stall: assert property (@(posedge ref_clk) disable iff (!rstn)
    issue && is_mul && req_dp |=> !(issue && is_arith))
    else $error("arithmetic issued in double multiply second cycle");
  a_ls_serial: assert property (@(posedge ref_clk) disable iff (!rstn)
    issue && is_ls |-> !(ls_busy && host_ls_stall))
    else $error("transfer issued behind stalled transfer");
  a_issue_gate: assert property (@(posedge ref_clk) disable iff (!rstn)
    issue |-> data_ok && res_ok)
    else $error("issue while blocked");
  a_fast_scalar: assert property (@(posedge ref_clk) disable iff (!rstn)
    fast_mode && !req_vec |-> src_lock == '0)
    else $error("scalar lock in fast mode");
  a_war_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
    issue && op == fphz_pkg::FPHZ_OP_LOAD_MULTIPLE |-> (ld_dst & src_sb_reg) == '0)
    else $error("load multiple over locked source");
  a_raw_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
    issue && is_arith |-> (src_all & ld_pend_reg & ~ld_arrive) == '0)
    else $error("arithmetic issued before loaded operand");
  a_ls_indep: assert property (@(posedge ref_clk) disable iff (!rstn)
    req_valid && is_arith && data_ok && !mac_busy_reg && it_left_reg <= 4'h1 && dv_left_reg == 3'h0
    && op != fphz_pkg::FPHZ_OP_DIV |-> issue)
    else $error("arithmetic held by load/store");
endmodule

// file: fphz_pkg.sv
// Shared constants and types for the coprocessor hazard interlock
package fphz_pkg;
  localparam int REG_W = 5;
  localparam int NREGS = 32;
  localparam int BANK_SZ = 8;
  localparam logic [2:0] LEN_TWO = 3'h1;
  localparam logic [2:0] LEN_FOUR = 3'h3;
  localparam logic [1:0] STRIDE_ONE = 2'h0;
  localparam int FAST_SP_MAX_ITER = 4;
  localparam int FAST_DP_MAX_ITER = 2;
  localparam int DP_MUL_OCC = 2;
  localparam int SP_DIV_BLOCK = 15;
  localparam int DP_DIV_BLOCK = 29;
  localparam int SP_DIV_ITER = 14;
  localparam int DIV_CNT_W = 5;
  typedef enum logic [2:0] {
    FPHZ_OP_NONE = 3'b000,
    FPHZ_OP_LOAD_SINGLE = 3'b001,
    FPHZ_OP_LOAD_MULTIPLE = 3'b010,
    FPHZ_OP_ADD = 3'b011,
    FPHZ_OP_MUL = 3'b100,
    FPHZ_OP_DIV = 3'b101
  } fphz_op_t;
  typedef enum logic [1:0] {
    FPHZ_LS_IDLE = 2'b00,
    FPHZ_LS_BUSY = 2'b01
  } fphz_ls_state_t;
endpackage

// file: fphz_reg_vec.sv
// Register mask of a vector operand with bank wrap
`timescale 1ns/1ps
module fphz_reg_vec (
  input wire logic [4:0] base,          // First register
  input wire logic [2:0] len,           // Iterations minus one
  input wire logic [1:0] stride,        // Stride code
  input wire logic [2:0] first_iter,    // First iteration to include
  output logic [31:0] mask              // One bit per register
);
  logic [2:0] step;
  always_comb begin
    step = (stride == fphz_pkg::STRIDE_ONE) ? 3'h1 : 3'h2;
  end
  genvar i;
  logic [31:0] part [8];
  generate
    for (i = 0; i < 8; i++) begin : g_it
      logic [2:0] off;
      always_comb begin
        off = 3'(base[2:0] + 3'(step * 3'(i)));
        part[i] = '0;
        if (3'(i) <= len && 3'(i) >= first_iter) begin
          part[i][{base[4:3], off}] = 1'b1;
        end
      end
    end
  endgenerate
  always_comb begin
    mask = '0;
    for (int j = 0; j < 8; j++) begin
      mask = mask | part[j];
    end
  end
endmodule

// file: fphz_host_model.sv
// Host core model: returns arithmetic writebacks a fixed time after issue
`timescale 1ns/1ps
module fphz_host_model #(
  parameter int WB_LAT = 8
) (
  input wire logic ref_clk,            // Core clock
  input wire logic rstn,               // Async reset, active low
  input wire logic issue,              // Instruction taken this cycle
  input wire logic [2:0] req_op,       // Operation code
  input wire logic [4:0] req_dst,      // Destination register
  output logic arith_wb,               // Writeback pulse
  output logic [4:0] arith_wb_reg      // Register written back
);
  logic [WB_LAT-1:0] wb_v_reg;
  logic [WB_LAT-1:0] wb_v_next;
  logic [4:0] wb_r_reg [WB_LAT];
  logic [4:0] wb_r_next [WB_LAT];
  ////////////////////////////////////////////////////////////////
  always_comb begin
    wb_v_next = {wb_v_reg[WB_LAT-2:0], issue && (req_op >= fphz_pkg::FPHZ_OP_ADD)};
    wb_r_next[0] = req_dst;
    for (int i = 1; i < WB_LAT; i++) begin
      wb_r_next[i] = wb_r_reg[i-1];
    end
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wb_v_reg <= '0;
      for (int i = 0; i < WB_LAT; i++) begin
        wb_r_reg[i] <= 5'h00;
      end
    end else begin
      wb_v_reg <= wb_v_next;
      wb_r_reg <= wb_r_next;
    end
  end
  ////////////////////////////////////////////////////////////////
  // Idle register lines show the inverted stale register value
  assign arith_wb = wb_v_reg[WB_LAT-1];
  assign arith_wb_reg = arith_wb ? wb_r_reg[WB_LAT-1] : ~wb_r_reg[WB_LAT-1];
endmodule

// file: tb_top.sv
// Self-checking bench for the issue interlock
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin err_count++; \
  $display("unexpected %s expected %0h seen %0h", nm, exp, got); end end
module tb_top;
  logic ref_clk = 0, rstn = 0, fast_mode = 0, req_valid = 0, req_dp = 0, req_vec = 0, host_ls_stall = 0;
  logic [2:0] vector_length_field = 3'h0, req_op = 3'h0;
  logic [1:0] stride_field = 2'h0;
  logic [4:0] req_dst = 5'h00, req_src_a = 5'h00, req_src_b = 5'h00, req_count = 5'h00, arith_wb_reg;
  logic arith_wb, issue, fwd_load, fwd_arith, ls_busy;
  int err_count = 0, checks_done = 0, seed = 8534, n;
  always #2.5 ref_clk = ~ref_clk;
  fphz_interlock u_fphz_interlock (.ref_clk(ref_clk), .rstn(rstn), .fast_mode(fast_mode),
    .vector_length_field(vector_length_field), .stride_field(stride_field), .req_valid(req_valid),
    .req_op(req_op), .req_dp(req_dp), .req_vec(req_vec), .req_dst(req_dst), .req_src_a(req_src_a),
    .req_src_b(req_src_b), .req_count(req_count), .host_ls_stall(host_ls_stall), .arith_wb(arith_wb),
    .arith_wb_reg(arith_wb_reg), .issue(issue), .fwd_load(fwd_load), .fwd_arith(fwd_arith), .ls_busy(ls_busy));
  fphz_host_model u_fphz_host_model (.ref_clk(ref_clk), .rstn(rstn), .issue(issue), .req_op(req_op),
    .req_dst(req_dst), .arith_wb(arith_wb), .arith_wb_reg(arith_wb_reg));
  ////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic do_reset(input logic fm, input logic [2:0] len);
    @(posedge ref_clk);
    rstn <= 1'b0;
    req_valid <= 1'b0;
    host_ls_stall <= 1'b0;
    fast_mode <= fm;
    vector_length_field <= len;
    repeat (6) @(posedge ref_clk);
    rstn <= 1'b1;
  endtask
  task automatic put(input fphz_pkg::fphz_op_t op, input logic dp, vec, input logic [4:0] d, a, b, c);
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_op <= op;
    req_dp <= dp;
    req_vec <= vec;
    req_dst <= d;
    req_src_a <= a;
    req_src_b <= b;
    req_count <= c;
    #1;
  endtask
  // Bounded wait for the held request to be taken
  task automatic wait_iss(output int k);
    k = 0;
    while (issue !== 1'b1 && k < 100) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    if (k >= 100) err_count++;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    #50000;
    err_count++;
    end_sim();
  end
  initial begin
    repeat (12) begin
      do_reset(1'($random(seed)), 3'($random(seed)));
      put(fphz_pkg::FPHZ_OP_ADD, 1'($random(seed)), 1'b0, 5'($random(seed)), 5'($random(seed)),
        5'($random(seed)), 5'h00);
      `CHK("issue", 1'b1, issue)
      `CHK("ls_busy", 1'b0, ls_busy)
    end
    $display("random issue test done");
    do_reset(1'b0, fphz_pkg::LEN_TWO);
    put(fphz_pkg::FPHZ_OP_MUL, 1'b1, 1'b0, 5'h01, 5'h02, 5'h03, 5'h00);
    put(fphz_pkg::FPHZ_OP_ADD, 1'b0, 1'b0, 5'h05, 5'h06, 5'h07, 5'h00);
    `CHK("issue", 1'b0, issue)
    wait_iss(n);
    `CHK("mul_stall", fphz_pkg::DP_MUL_OCC - 1, n)
    $display("double multiply test done");
    do_reset(1'b0, fphz_pkg::LEN_TWO);
    put(fphz_pkg::FPHZ_OP_MUL, 1'b0, 1'b0, 5'h04, 5'h01, 5'h00, 5'h00);
    put(fphz_pkg::FPHZ_OP_ADD, 1'b0, 1'b0, 5'h05, 5'h04, 5'h03, 5'h00);
    `CHK("issue", 1'b0, issue)
    wait_iss(n);
    `CHK("raw_stall", u_fphz_host_model.WB_LAT - 1, n)
    `CHK("wb", 1'b1, arith_wb === 1'b1 && arith_wb_reg === 5'h04)
    `CHK("fwd_arith", 1'b1, fwd_arith)
    $display("arithmetic forwarding test done");
    for (int dp = 0; dp < 2; dp++) begin
      do_reset(1'b0, fphz_pkg::LEN_TWO);
      put(fphz_pkg::FPHZ_OP_DIV, 1'(dp), 1'b0, 5'h01, 5'h02, 5'h03, 5'h00);
      put(fphz_pkg::FPHZ_OP_DIV, 1'(dp), 1'b0, 5'h04, 5'h05, 5'h06, 5'h00);
      wait_iss(n);
      `CHK("div_block", (dp ? fphz_pkg::DP_DIV_BLOCK : fphz_pkg::SP_DIV_BLOCK) - 1, n)
    end
    $display("divide block test done");
    do_reset(1'b0, fphz_pkg::LEN_TWO);
    put(fphz_pkg::FPHZ_OP_DIV, 1'b0, 1'b1, 5'h08, 5'h0a, 5'h0c, 5'h00);
    put(fphz_pkg::FPHZ_OP_ADD, 1'b0, 1'b0, 5'h00, 5'h00, 5'h01, 5'h00);
    wait_iss(n);
    `CHK("vec_div_stall", fphz_pkg::SP_DIV_ITER + 1, n)
    $display("vector divide test done");
    do_reset(1'b0, fphz_pkg::LEN_FOUR);
    put(fphz_pkg::FPHZ_OP_LOAD_MULTIPLE, 1'b0, 1'b0, 5'h00, 5'h00, 5'h00, 5'h06);
    `CHK("issue", 1'b1, issue)
    put(fphz_pkg::FPHZ_OP_ADD, 1'b0, 1'b1, 5'h10, 5'h07, 5'h18, 5'h00);
    `CHK("issue", 1'b0, issue)
    wait_iss(n);
    `CHK("fwd_load", 1'b1, fwd_load)
    `CHK("ls_busy", 1'b1, ls_busy)
    do_reset(1'b0, fphz_pkg::LEN_FOUR);
    put(fphz_pkg::FPHZ_OP_LOAD_MULTIPLE, 1'b0, 1'b0, 5'h08, 5'h00, 5'h00, 5'h03);
    put(fphz_pkg::FPHZ_OP_MUL, 1'b0, 1'b1, 5'h10, 5'h18, 5'h04, 5'h00);
    `CHK("issue", 1'b1, issue)
    $display("load multiple vector test done");
    do_reset(1'b0, fphz_pkg::LEN_TWO);
    put(fphz_pkg::FPHZ_OP_LOAD_MULTIPLE, 1'b0, 1'b0, 5'h08, 5'h00, 5'h00, 5'h02);
    put(fphz_pkg::FPHZ_OP_LOAD_SINGLE, 1'b0, 1'b0, 5'h10, 5'h00, 5'h00, 5'h01);
    `CHK("issue", 1'b0, issue)
    @(posedge ref_clk);
    host_ls_stall <= 1'b1;
    repeat (10) @(posedge ref_clk);
    #1;
    `CHK("issue", 1'b0, issue)
    `CHK("ls_busy", 1'b1, ls_busy)
    @(posedge ref_clk);
    host_ls_stall <= 1'b0;
    #1;
    wait_iss(n);
    `CHK("issue", 1'b1, issue)
    $display("transfer stall test done");
    for (int k = 0; k < 4; k++) begin
      do_reset(k > 0, (k == 3) ? 3'h4 : fphz_pkg::LEN_FOUR);
      put(fphz_pkg::FPHZ_OP_MUL, 1'b0, k != 2, 5'h08, 5'h10, 5'h18, 5'h00);
      put(fphz_pkg::FPHZ_OP_LOAD_MULTIPLE, 1'b0, 1'b0, 5'h10, 5'h00, 5'h00, 5'h0c);
      `CHK("issue", 1'(k == 1 || k == 2), issue)
      if (k == 0) begin
        wait_iss(n);
        `CHK("war_stall", 4, n)
      end
    end
    $display("source lock test done");
    @(posedge ref_clk);
    req_valid <= 1'b0;
    end_sim();
  end
endmodule
